// [verilog/ecgft_pkg.sv]
// How it works
// - Two-bit low-pass select: 00 40 Hz default, 01 150, 10 250, 11 450 Hz.
// - Filter control bit 4: 0 keeps 2 kHz notch on normal path, 1 bypasses.
// - Filter control bit 5: 0 bypasses master-path notch, 1 inserts it.
// - Out-of-range when code exceeds max minus over-range setting times 64; 0 disables.
// - Out-of-range when code below min plus under-range setting times 64; 0 disables.
// - AC lead-off when measured level >= 16-bit upper threshold; resets to all ones.
// - AC lead-off when measured level <= 16-bit lower threshold; zero means 0 V.
// - Three 8-bit pace edge levels: ch3 [23:16], ch2 [15:8], ch1 [7:0].
package ecgft_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_FRAME_CONTROL = 8'h0a;
  localparam logic [7:0] IDX_FILTER_CONTROL = 8'h0b;
  localparam logic [7:0] IDX_LEADOFF_UPPER = 8'h0c;
  localparam logic [7:0] IDX_LEADOFF_LOWER = 8'h0d;
  localparam logic [7:0] IDX_PACE_EDGE = 8'h0e;
  localparam logic [7:0] IDX_EVENT_STATUS = 8'h18;
  localparam logic [7:0] IDX_EVENT_MASK = 8'h19;
  localparam logic [7:0] IDX_CHECK_CONTROL = 8'h1a;
  localparam logic [7:0] IDX_CHECK_RESULT = 8'h1b;

  localparam int unsigned REG_W = 24;
  localparam int unsigned PADDR_W = 8;

  // Reset values
  localparam logic [23:0] RST_FRAME_CONTROL = 24'h079000;
  localparam logic [23:0] RST_FILTER_CONTROL = 24'h000000;
  localparam logic [23:0] RST_LEADOFF_UPPER = 24'h00ffff;
  localparam logic [23:0] RST_LEADOFF_LOWER = 24'h000000;
  localparam logic [23:0] RST_PACE_EDGE = 24'h000000;
  localparam logic [3:0] RST_EVENT_MASK = 4'h0;
  localparam logic [0:0] RST_CHECK_CONTROL = 1'h1;

  // Field positions
  localparam int unsigned LPF_LSB = 2;
  localparam int unsigned NOTCH_BYPASS_BIT = 4;
  localparam int unsigned MASTER_NOTCH_BIT = 5;
  localparam int unsigned RANGE_LSB = 16;
  localparam int unsigned LEVEL_LSB = 0;
  localparam int unsigned PACE1_LSB = 0;
  localparam int unsigned PACE2_LSB = 8;
  localparam int unsigned PACE3_LSB = 16;
  localparam int unsigned AC_CHECK_BIT = 0;

  // Event bits of status and mask
  localparam int unsigned NUM_EVT = 4;
  localparam int unsigned EVT_OVER = 0;
  localparam int unsigned EVT_UNDER = 1;
  localparam int unsigned EVT_LO_UPPER = 2;
  localparam int unsigned EVT_LO_LOWER = 3;

  // One range step is 2^6 codes
  localparam int unsigned RANGE_STEP_SHIFT = 6;

  typedef enum logic [1:0] {
    CORNER_40HZ,
    CORNER_150HZ,
    CORNER_250HZ,
    CORNER_450HZ
  } ecgft_corner_t;

  typedef struct packed {
    logic valid;
    logic [23:0] code;
    logic [15:0] leadoff_level;
  } ecgft_conv_t;

  typedef struct packed {
    ecgft_corner_t lowpass_corner_select;
    logic notch_bypass;
    logic master_path_notch_insert;
  } ecgft_filt_cfg_t;

  typedef struct packed {
    logic [7:0] pace_ch3_edge_level;
    logic [7:0] pace_ch2_edge_level;
    logic [7:0] pace_ch1_edge_level;
  } ecgft_pace_cfg_t;

  function automatic logic [23:0] range_offset(input logic [3:0] n);
    range_offset = {14'h0000, n, 6'h00};
  endfunction : range_offset

endpackage : ecgft_pkg

// [verilog/ecgft_range_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module ecgft_range_chk
  import ecgft_pkg::*;
#(
  parameter logic [23:0] MAX_CODE = 24'hffffff,
  parameter logic [23:0] MIN_CODE = 24'h000000
) (
  // Conversion code
  input wire logic [23:0] code,
  // Offsets in steps of 64 codes
  input wire logic [3:0] overrange_offset,
  input wire logic [3:0] underrange_offset,
  // Hits
  output logic over_hit,
  output logic under_hit
);

  logic [23:0] over_limit;
  logic [23:0] under_limit;

  assign over_limit = MAX_CODE - range_offset(overrange_offset);
  assign under_limit = MIN_CODE + range_offset(underrange_offset);
  // Zero setting leaves the limit at full scale, where no code can pass
  assign over_hit = (overrange_offset != 4'h0) && (code > over_limit);
  assign under_hit = (underrange_offset != 4'h0) && (code < under_limit);

endmodule : ecgft_range_chk
`default_nettype wire

// [verilog/ecgft_leadoff_cmp.sv]
`timescale 1ns/1ps
`default_nettype none
module ecgft_leadoff_cmp
  import ecgft_pkg::*;
(
  // Measured ac lead-off level
  input wire logic [15:0] level,
  input wire logic enable,
  // Thresholds
  input wire logic [15:0] upper_leadoff_level,
  input wire logic [15:0] lower_leadoff_level,
  // Hits
  output logic upper_hit,
  output logic lower_hit
);

  assign upper_hit = enable && (level >= upper_leadoff_level);
  assign lower_hit = enable && (level <= lower_leadoff_level);

endmodule : ecgft_leadoff_cmp
`default_nettype wire

// [verilog/ecgft_top.sv]
`timescale 1ns/1ps
`default_nettype none
module ecgft_top
  import ecgft_pkg::*;
#(
  parameter logic [23:0] MAX_CODE = 24'hffffff,
  parameter logic [23:0] MIN_CODE = 24'h000000
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Conversion results from the ADC path
  input wire ecgft_conv_t conv,
  // Configuration to the filter and pace logic, and the frame control word
  output ecgft_filt_cfg_t filt_cfg,
  output ecgft_pace_cfg_t pace_cfg,
  output logic [REG_W-1:0] frame_control,
  // Per-conversion check results
  output logic adc_out_of_range,
  output logic leadoff_detected,
  // Interrupt
  output logic irq
);

  // Register storage
  logic [REG_W-1:0] frame_control_r;
  logic [1:0] lpf_r;
  logic notch_bypass_r;
  logic master_notch_r;
  logic [3:0] over_off_r;
  logic [15:0] upper_level_r;
  logic [3:0] under_off_r;
  logic [15:0] lower_level_r;
  logic [23:0] pace_r;
  logic [NUM_EVT-1:0] status_r;
  logic [NUM_EVT-1:0] status_nxt;
  logic [NUM_EVT-1:0] status_clr;
  logic [NUM_EVT-1:0] mask_r;
  logic ac_check_r;
  logic [NUM_EVT-1:0] last_hits_r;

  // APB handshake and the other output flops
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic irq_r;
  logic out_of_range_r;
  logic leadoff_r;

  // Bus decode
  logic access_ph;
  logic wr_en;
  logic rd_en;
  logic wr_frame;
  logic wr_filter;
  logic wr_upper;
  logic wr_lower;
  logic wr_pace;
  logic wr_status;
  logic wr_mask;
  logic wr_check;
  logic sel_frame;
  logic sel_filter;
  logic sel_upper;
  logic sel_lower;
  logic sel_pace;
  logic sel_status;
  logic sel_mask;
  logic sel_check;
  logic sel_result;
  logic addr_hit;
  logic [31:0] rd_mux;

  assign access_ph = psel && penable;
  // One wait state: the answer comes on the second access cycle
  assign wr_en = access_ph && pready_r && pwrite && addr_hit;
  assign rd_en = access_ph && !pready_r;
  // Misaligned byte addresses select nothing
  function automatic logic reg_at(input logic [PADDR_W-1:0] addr, input logic [7:0] index);
    reg_at = (addr[1:0] == 2'b00) && ({2'b00, addr[PADDR_W-1:2]} == index);
  endfunction : reg_at

  assign sel_frame = reg_at(paddr, IDX_FRAME_CONTROL);
  assign sel_filter = reg_at(paddr, IDX_FILTER_CONTROL);
  assign sel_upper = reg_at(paddr, IDX_LEADOFF_UPPER);
  assign sel_lower = reg_at(paddr, IDX_LEADOFF_LOWER);
  assign sel_pace = reg_at(paddr, IDX_PACE_EDGE);
  assign sel_status = reg_at(paddr, IDX_EVENT_STATUS);
  assign sel_mask = reg_at(paddr, IDX_EVENT_MASK);
  assign sel_check = reg_at(paddr, IDX_CHECK_CONTROL);
  assign sel_result = reg_at(paddr, IDX_CHECK_RESULT);
  assign addr_hit = sel_frame || sel_filter || sel_upper || sel_lower || sel_pace
    || sel_status || sel_mask || sel_check || sel_result;

  // One strobe per register keeps the write processes short
  assign wr_frame = wr_en && sel_frame;
  assign wr_filter = wr_en && sel_filter;
  assign wr_upper = wr_en && sel_upper;
  assign wr_lower = wr_en && sel_lower;
  assign wr_pace = wr_en && sel_pace;
  assign wr_status = wr_en && sel_status;
  assign wr_mask = wr_en && sel_mask;
  assign wr_check = wr_en && sel_check;

  // Read data; reserved bits read as zero
  logic [23:0] filter_word;
  logic [23:0] upper_word;
  logic [23:0] lower_word;

  assign filter_word = {18'h00000, master_notch_r, notch_bypass_r, lpf_r, 2'b00};
  assign upper_word = {4'h0, over_off_r, upper_level_r};
  assign lower_word = {4'h0, under_off_r, lower_level_r};
  assign rd_mux = sel_frame ? {8'h00, frame_control_r} :
                  sel_filter ? {8'h00, filter_word} :
                  sel_upper ? {8'h00, upper_word} :
                  sel_lower ? {8'h00, lower_word} :
                  sel_pace ? {8'h00, pace_r} :
                  sel_status ? {28'h0000000, status_r} :
                  sel_mask ? {28'h0000000, mask_r} :
                  sel_check ? {31'h00000000, ac_check_r} :
                  sel_result ? {28'h0000000, last_hits_r} :
                  32'h00000000;

  // Writes and refused reads return zero
  logic resp_err;
  logic [31:0] rd_word;

  assign resp_err = rd_en && !addr_hit;
  assign rd_word = (!pwrite && addr_hit) ? rd_mux : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      pready_r <= rd_en;
      pslverr_r <= resp_err;
      if (rd_en) begin
        prdata_r <= rd_word;
      end
    end
  end

  // Writable registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_control_r <= RST_FRAME_CONTROL;
    end else if (wr_frame) begin
      frame_control_r <= pwdata[REG_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lpf_r <= RST_FILTER_CONTROL[LPF_LSB +: 2];
      notch_bypass_r <= RST_FILTER_CONTROL[NOTCH_BYPASS_BIT];
      master_notch_r <= RST_FILTER_CONTROL[MASTER_NOTCH_BIT];
    end else if (wr_filter) begin
      lpf_r <= pwdata[LPF_LSB +: 2];
      notch_bypass_r <= pwdata[NOTCH_BYPASS_BIT];
      master_notch_r <= pwdata[MASTER_NOTCH_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      over_off_r <= RST_LEADOFF_UPPER[RANGE_LSB +: 4];
      upper_level_r <= RST_LEADOFF_UPPER[LEVEL_LSB +: 16];
    end else if (wr_upper) begin
      over_off_r <= pwdata[RANGE_LSB +: 4];
      upper_level_r <= pwdata[LEVEL_LSB +: 16];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      under_off_r <= RST_LEADOFF_LOWER[RANGE_LSB +: 4];
      lower_level_r <= RST_LEADOFF_LOWER[LEVEL_LSB +: 16];
    end else if (wr_lower) begin
      under_off_r <= pwdata[RANGE_LSB +: 4];
      lower_level_r <= pwdata[LEVEL_LSB +: 16];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pace_r <= RST_PACE_EDGE;
    end else if (wr_pace) begin
      pace_r <= pwdata[23:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= RST_EVENT_MASK;
    end else if (wr_mask) begin
      mask_r <= pwdata[NUM_EVT-1:0];
    end
  end

  // Lead-off compare enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ac_check_r <= RST_CHECK_CONTROL[0];
    end else if (wr_check) begin
      ac_check_r <= pwdata[AC_CHECK_BIT];
    end
  end

  // Checks on each conversion
  logic over_hit;
  logic under_hit;
  logic upper_hit;
  logic lower_hit;
  logic [NUM_EVT-1:0] hits;
  logic [NUM_EVT-1:0] events;

  ecgft_range_chk #(
    .MAX_CODE(MAX_CODE),
    .MIN_CODE(MIN_CODE)
  ) u_range (
    .code(conv.code),
    .overrange_offset(over_off_r),
    .underrange_offset(under_off_r),
    .over_hit(over_hit),
    .under_hit(under_hit)
  );

  // Lead-off levels only mean anything in ac lead-off mode
  ecgft_leadoff_cmp u_leadoff (
    .level(conv.leadoff_level),
    .enable(ac_check_r),
    .upper_leadoff_level(upper_level_r),
    .lower_leadoff_level(lower_level_r),
    .upper_hit(upper_hit),
    .lower_hit(lower_hit)
  );

  always_comb begin
    hits = '0;
    hits[EVT_OVER] = over_hit;
    hits[EVT_UNDER] = under_hit;
    hits[EVT_LO_UPPER] = upper_hit;
    hits[EVT_LO_LOWER] = lower_hit;
  end

  // Only a fresh conversion raises events; thresholds are the live ones
  assign events = conv.valid ? hits : '0;

  logic range_hit;
  logic lo_hit;

  assign range_hit = over_hit || under_hit;
  assign lo_hit = upper_hit || lower_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_hits_r <= '0;
      out_of_range_r <= 1'b0;
      leadoff_r <= 1'b0;
    end else if (conv.valid) begin
      last_hits_r <= hits;
      out_of_range_r <= range_hit;
      leadoff_r <= lo_hit;
    end
  end

  // Sticky status, write one to clear; a new event wins over the clear
  assign status_clr = wr_status ? pwdata[NUM_EVT-1:0] : '0;
  assign status_nxt = (status_r & ~status_clr) | events;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= '0;
      irq_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      irq_r <= |(status_nxt & mask_r);
    end
  end

  // Outputs straight from flops
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign filt_cfg.lowpass_corner_select = ecgft_corner_t'(lpf_r);
  assign filt_cfg.notch_bypass = notch_bypass_r;
  assign filt_cfg.master_path_notch_insert = master_notch_r;
  assign pace_cfg.pace_ch3_edge_level = pace_r[PACE3_LSB +: 8];
  assign pace_cfg.pace_ch2_edge_level = pace_r[PACE2_LSB +: 8];
  assign pace_cfg.pace_ch1_edge_level = pace_r[PACE1_LSB +: 8];
  assign frame_control = frame_control_r;
  assign adc_out_of_range = out_of_range_r;
  assign leadoff_detected = leadoff_r;
  assign irq = irq_r;

endmodule : ecgft_top
`default_nettype wire

// [tb/ecgft_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module ecgft_asserts
  import ecgft_pkg::*;
#(
  parameter logic [23:0] MAX_CODE = 24'hffffff,
  parameter logic [23:0] MIN_CODE = 24'h000000
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Conversion and outputs
  input wire ecgft_conv_t conv,
  input wire ecgft_filt_cfg_t filt_cfg,
  input wire ecgft_pace_cfg_t pace_cfg,
  input wire logic [REG_W-1:0] frame_control,
  input wire logic adc_out_of_range,
  input wire logic leadoff_detected,
  input wire logic irq
);
  logic [31:0] wd_r;
  logic wr_ok;
  assign wr_ok = psel && penable && pready && pwrite && !pslverr;
  // Write data as held at the previous edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wd_r <= 32'h00000000;
    else wd_r <= pwdata;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_slverr_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_one_wait: assert property (psel && penable && !$past(penable) |-> ##1 pready)
    else $error("wait state count wrong");
  a_range_mid: assert property (conv.valid && conv.code > MIN_CODE + 24'd960 &&
    conv.code < MAX_CODE - 24'd960 |=> !adc_out_of_range) else $error("range flag wrong");
  a_flags_hold: assert property (!conv.valid |=> $stable(adc_out_of_range) &&
    $stable(leadoff_detected)) else $error("flag moved without conversion");
  a_cfg_stable: assert property (!wr_ok |=> $stable(filt_cfg) && $stable(pace_cfg))
    else $error("config moved without write");
  a_filt_value: assert property (wr_ok && paddr == 8'h2c |=>
    filt_cfg == {wd_r[3:2], wd_r[4], wd_r[5]}) else $error("filter fields wrong");
  a_pace_value: assert property (wr_ok && paddr == 8'h38 |=> pace_cfg == wd_r[23:0])
    else $error("pace fields wrong");
  a_frame_value: assert property (wr_ok && paddr == 8'h28 |=> frame_control == wd_r[23:0])
    else $error("frame control word wrong");
  a_misalign_err: assert property (psel && penable && !pready && paddr[1:0] != 2'b00 |=>
    pslverr) else $error("misaligned access not refused");
endmodule : ecgft_asserts
bind ecgft_top ecgft_asserts #(.MAX_CODE(MAX_CODE), .MIN_CODE(MIN_CODE)) u_ecgft_asserts (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .conv(conv), .filt_cfg(filt_cfg), .pace_cfg(pace_cfg), .frame_control(frame_control),
  .adc_out_of_range(adc_out_of_range), .leadoff_detected(leadoff_detected), .irq(irq));
`default_nettype wire

// [tb/ecgft_host.sv]
`timescale 1ns/1ps
`default_nettype none
module ecgft_host (
  // Clock
  input wire logic pclk,
  // APB answer
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  // APB request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  // Read result, one cycle
  output logic rd_done,
  output logic [32:0] rd_res
);
  initial begin
    {psel, penable, pwrite, rd_done} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    rd_res = 33'h000000000;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd_done <= !w;
    rd_res <= {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines must not keep showing the old value
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge pclk);
    rd_done <= 1'b0;
  endtask : xfer
endmodule : ecgft_host
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ecgft_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_done;
  logic adc_out_of_range, leadoff_detected, irq, irq_exp;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, w;
  logic [32:0] rd_res;
  logic [23:0] frame_control;
  logic [15:0] lfsr_r;
  ecgft_conv_t conv;
  ecgft_filt_cfg_t filt_cfg;
  ecgft_pace_cfg_t pace_cfg;
  logic [32:0] exp_q[$];
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  ecgft_top u_ecgft_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conv(conv), .filt_cfg(filt_cfg), .pace_cfg(pace_cfg),
    .frame_control(frame_control), .adc_out_of_range(adc_out_of_range),
    .leadoff_detected(leadoff_detected), .irq(irq));
  ecgft_host u_ecgft_host (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .rd_done(rd_done), .rd_res(rd_res));
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rnd(output logic [31:0] r);
    repeat (32) lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    r = {lfsr_r, lfsr_r[7:0], lfsr_r[15:8]};
  endtask : rnd
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    u_ecgft_host.xfer(1'b0, a, 32'h00000000);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_ecgft_host.xfer(1'b1, a, d);
  endtask : wr
  task automatic cv(input logic [23:0] c, input logic [15:0] l, input logic er, input logic el);
    conv <= '{1'b1, c, l};
    @(posedge pclk);
    conv.valid <= 1'b0;
    @(posedge pclk);
    chk({32'h0, adc_out_of_range}, {32'h0, er});
    chk({32'h0, leadoff_detected}, {32'h0, el});
    chk({32'h0, irq}, {32'h0, irq_exp});
  endtask : cv
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (rd_done === 1'b1) begin
      if (exp_q.size() == 0) error_cnt++;
      else chk(rd_res, exp_q.pop_front());
    end
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial begin
    presetn = 1'b0;
    conv = '0;
    irq_exp = 1'b0;
    lfsr_r = 16'h532c;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({29'h0, filt_cfg}, 33'h0);
    rd(8'h28, 33'h079000);
    rd(8'h2c, 33'h0);
    rd(8'h30, 33'h00ffff);
    rd(8'h34, 33'h0);
    rd(8'h38, 33'h0);
    rd(8'h3c, 33'h100000000);
    rd(8'h29, 33'h100000000);
    // Offsets still zero: range checks disabled
    cv(24'hffffff, 16'h4000, 1'b0, 1'b0);
    cv(24'h000000, 16'h4000, 1'b0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      rnd(w);
      w[5:2] = {~i[1:0], i[1:0]};
      wr(8'h2c, w);
      chk({29'h0, filt_cfg}, {29'h0, w[3:2], w[4], w[5]});
      rd(8'h2c, {27'h0, w[5:2], 2'b00});
    end
    rnd(w);
    wr(8'h38, w);
    chk({9'h0, pace_cfg}, {9'h0, w[23:0]});
    rd(8'h38, {9'h0, w[23:0]});
    wr(8'h30, 32'hfff38000);
    rd(8'h30, 33'h038000);
    wr(8'h34, 32'hfff20100);
    rd(8'h34, 33'h020100);
    cv(24'hffff40, 16'h4000, 1'b1, 1'b0);
    cv(24'hffff3f, 16'h4000, 1'b0, 1'b0);
    cv(24'h00007f, 16'h4000, 1'b1, 1'b0);
    cv(24'h000080, 16'h4000, 1'b0, 1'b0);
    cv(24'h800000, 16'h8000, 1'b0, 1'b1);
    cv(24'h800000, 16'h7fff, 1'b0, 1'b0);
    cv(24'h800000, 16'h0100, 1'b0, 1'b1);
    cv(24'h800000, 16'h0101, 1'b0, 1'b0);
    repeat (4) begin
      rnd(w);
      cv({2'b01, w[21:0]}, {2'b01, w[13:0]}, 1'b0, 1'b0);
    end
    wr(8'h60, 32'h0000000f);
    wr(8'h64, 32'h00000001);
    rd(8'h64, 33'h1);
    cv(24'h00007f, 16'h4000, 1'b1, 1'b0);
    irq_exp = 1'b1;
    cv(24'hffffff, 16'h4000, 1'b1, 1'b0);
    rd(8'h60, 33'h3);
    wr(8'h60, 32'h00000001);
    @(posedge pclk);
    chk({32'h0, irq}, 33'h0);
    rd(8'h60, 33'h2);
    rd(8'h6c, 33'h1);
    irq_exp = 1'b0;
    wr(8'h68, 32'h00000000);
    cv(24'h800000, 16'h8000, 1'b0, 1'b0);
    cv(24'h800000, 16'h0100, 1'b0, 1'b0);
    rd(8'h6c, 33'h0);
    wr(8'h28, 32'h00abcdef);
    chk({9'h0, frame_control}, 33'h0abcdef);
    rd(8'h28, 33'h0abcdef);
    repeat (3) @(posedge pclk);
    if (exp_q.size() != 0) error_cnt++;
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
